// ===== tmrctr_params.svh
`ifndef TMRCTR_PARAMS_SVH
`define TMRCTR_PARAMS_SVH

// register indices; byte address is four times the index
`define TMRCTR_IDX_CTRL 10'h088
`define TMRCTR_IDX_MODE 10'h089
`define TMRCTR_IDX_LO0 10'h08A
`define TMRCTR_IDX_HI0 10'h08B
`define TMRCTR_IDX_LO1 10'h08C
`define TMRCTR_IDX_HI1 10'h08D
`define TMRCTR_IDX_CLK 10'h08E

// timer_control_flags bit positions
`define TMRCTR_OVF1 7
`define TMRCTR_RUN1 6
`define TMRCTR_OVF0 5
`define TMRCTR_RUN0 4
`define TMRCTR_EXF1 3
`define TMRCTR_EXT1 2
`define TMRCTR_EXF0 1
`define TMRCTR_EXT0 0

// timer_mode_select field offsets inside one timer's nibble
`define TMRCTR_MODE_W 4
`define TMRCTR_GATE 3
`define TMRCTR_SRC 2
`define TMRCTR_MH 1
`define TMRCTR_ML 0

// reset values
`define TMRCTR_RST_BYTE 8'h00
`define TMRCTR_RST_SEL 2'h0

// oscillator cycles per time-base tick
`define TMRCTR_DIV_SLOW 12
`define TMRCTR_DIV_FAST 4

`endif

// ===== tmrctr_pkg.sv
package tmrctr_pkg;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } tmrctr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tmrctr_apb_rsp_t;

  typedef struct packed {
    logic count_pin_one;
    logic count_pin_zero;
    logic ext_irq_pin_one;
    logic ext_irq_pin_zero;
  } tmrctr_pins_t;

  typedef struct packed {
    logic overflow_flag_one;
    logic overflow_flag_zero;
    logic ext_irq_flag_one;
    logic ext_irq_flag_zero;
  } tmrctr_flags_t;

  typedef enum logic [1:0] {
    TMRCTR_M13,
    TMRCTR_M16,
    TMRCTR_M8_RELOAD,
    TMRCTR_M_SPLIT
  } tmrctr_mode_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [1:0][7:0] lo;
    logic [1:0][7:0] hi;
    logic [1:0] divsel;
    logic [3:0] pre;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [1:0] irq_prev;
    logic [1:0] cnt_samp;
    tmrctr_apb_rsp_t rsp;
    tmrctr_flags_t flags;
  } tmrctr_state_t;

endpackage

// ===== tmrctr_top.sv
// Decided for this implementation: register access over APB.
`include "tmrctr_params.svh"

// Notes on behaviour
// - timer ticks every 4 or 12 oscillator cycles per timer select bit
// - count pin needs one machine cycle high then one low to count
// - each timer picks its divisor alone, changeable while running
// - each count is low and high byte, readable and writable anytime
// - mode byte: timer 1 nibble on top, gate, source, mode high, mode low
// - gate set: count needs run bit and interrupt pin high; else run bit
// - source 0 counts internal ticks, source 1 counts falling count-pin edges
// - mode 0 13-bit, 1 16-bit, 2 8-bit reload, 3 stop or split
// - split mode exists for timer 0 only
// - control byte: ovf1 run1 ovf0 run0 extflag1 exttype1 extflag0 exttype0
// - overflow sets flag; vectoring to its handler clears it
// - type 1 falling edge, type 0 low level, either sets interrupt flag
// - 13-bit mode: low bits 0-4 carry straight into high bit 0
// - 13-bit wrap from 1FFF to 0 sets overflow flag
// - 16-bit: low byte least significant, FFFF wraps to 0, sets flag
// - timer 1 13-bit mode mirrors timer 0 with its own controls
// - reload mode: low counts, at FF reloads from unchanged high byte
// - split: timer 0 high byte ticks internally, uses run1 and ovf1
// - timer 1 in mode 3 stops and holds its count
module tmrctr_top
  import tmrctr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire tmrctr_pkg::tmrctr_apb_req_t apb_req,
  output tmrctr_pkg::tmrctr_apb_rsp_t apb_rsp,
  input wire tmrctr_pkg::tmrctr_pins_t pins,
  input wire tmrctr_pkg::tmrctr_flags_t vector_ack,
  output tmrctr_pkg::tmrctr_flags_t flags
);
  import tmrctr_pkg::*;

  localparam logic [3:0] PRE_LAST = 4'(`TMRCTR_DIV_SLOW - 1);
  localparam logic [1:0] MC_LAST = 2'(`TMRCTR_DIV_FAST - 1);

  logic [1:0] rst_sync_q;
  logic rst_n_sync;
  tmrctr_state_t s_q;
  tmrctr_state_t s_d;

  // 13/16/reload step of one timer; returns {overflow, high, low}
  function automatic logic [16:0] step_count(
    input tmrctr_mode_t m,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [13:0] s13;
    logic [16:0] s16;
    s13 = 14'h0000;
    s16 = 17'h00000;
    case (m)
      TMRCTR_M13:
      begin
        // upper three low bits are left untouched and carry no meaning
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        step_count = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      end
      TMRCTR_M16:
      begin
        s16 = {1'b0, hi, lo} + 17'h00001;
        step_count = s16;
      end
      TMRCTR_M8_RELOAD:
      begin
        if (lo == 8'hFF)
        begin
          step_count = {1'b1, hi, hi};
        end
        else
        begin
          step_count = {1'b0, hi, lo + 8'h01};
        end
      end
      default:
      begin
        step_count = {1'b0, hi, lo};
      end
    endcase
  endfunction

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n_sync = rst_sync_q[1];

  always_comb
  begin
    logic mc;
    logic [1:0] tb;
    logic [1:0] fall;
    logic [1:0] ev;
    logic [1:0] run;
    logic [1:0] ext_set;
    logic [3:0] md;
    logic [16:0] r;
    logic [8:0] r8;
    logic ov0;
    logic ov1;
    logic split;
    logic acc;
    logic done;
    logic hit;
    logic [9:0] idx;
    logic [7:0] rbyte;
    mc = 1'b0;
    tb = 2'h0;
    fall = 2'h0;
    ev = 2'h0;
    run = 2'h0;
    ext_set = 2'h0;
    md = 4'h0;
    r = 17'h00000;
    r8 = 9'h000;
    ov0 = 1'b0;
    ov1 = 1'b0;
    split = 1'b0;
    acc = 1'b0;
    done = 1'b0;
    hit = 1'b0;
    idx = 10'h000;
    rbyte = 8'h00;
    s_d = s_q;

    // one machine cycle is the fast divisor; slow divisor is a multiple of it
    mc = (s_q.pre[1:0] == MC_LAST);
    s_d.pre = (s_q.pre == PRE_LAST) ? 4'h0 : s_q.pre + 4'h1;

    s_d.pin_s1 = pins;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.irq_prev = s_q.pin_s2[1:0];

    split = (tmrctr_mode_t'(s_q.mode[1:0]) == TMRCTR_M_SPLIT);
    run[0] = s_q.ctrl[`TMRCTR_RUN0];
    // run1 belongs to the split high byte, so timer 1 free-runs then
    run[1] = split | s_q.ctrl[`TMRCTR_RUN1];

    for (int t = 0; t < 2; t++)
    begin
      md = s_q.mode[t * `TMRCTR_MODE_W +: `TMRCTR_MODE_W];
      tb[t] = s_q.divsel[t] ? mc : (s_q.pre == PRE_LAST);
      if (mc)
      begin
        // sampled once per machine cycle: high sample then low sample
        s_d.cnt_samp[t] = s_q.pin_s2[2 + t];
        fall[t] = s_q.cnt_samp[t] & ~s_q.pin_s2[2 + t];
      end
      ev[t] = run[t]
        & (~md[`TMRCTR_GATE] | s_q.pin_s2[t])
        & (md[`TMRCTR_SRC] ? fall[t] : tb[t]);
      if (s_q.ctrl[2 * t])
      begin
        ext_set[t] = s_q.irq_prev[t] & ~s_q.pin_s2[t];
      end
      else
      begin
        ext_set[t] = ~s_q.pin_s2[t];
      end
    end

    if (ev[0])
    begin
      if (split)
      begin
        r8 = {1'b0, s_q.lo[0]} + 9'h001;
        s_d.lo[0] = r8[7:0];
        ov0 = r8[8];
      end
      else
      begin
        r = step_count(tmrctr_mode_t'(s_q.mode[1:0]), s_q.lo[0], s_q.hi[0]);
        {ov0, s_d.hi[0], s_d.lo[0]} = r;
      end
    end

    // split high byte: internal ticks only, no gate, no count pin
    if (split && s_q.ctrl[`TMRCTR_RUN1] && tb[0])
    begin
      r8 = {1'b0, s_q.hi[0]} + 9'h001;
      s_d.hi[0] = r8[7:0];
      ov1 = r8[8];
    end

    if (ev[1] && tmrctr_mode_t'(s_q.mode[5:4]) != TMRCTR_M_SPLIT)
    begin
      r = step_count(tmrctr_mode_t'(s_q.mode[5:4]), s_q.lo[1], s_q.hi[1]);
      s_d.hi[1] = r[15:8];
      s_d.lo[1] = r[7:0];
      // timer 1 loses its flag while timer 0 is split
      ov1 = ov1 | (r[16] & ~split);
    end

    acc = apb_req.psel & apb_req.penable;
    done = acc & s_q.rsp.pready;
    idx = apb_req.paddr[11:2];
    hit = (apb_req.paddr[1:0] == 2'h0)
      & (idx >= `TMRCTR_IDX_CTRL) & (idx <= `TMRCTR_IDX_CLK);

    case (idx)
      `TMRCTR_IDX_CTRL: rbyte = s_q.ctrl;
      `TMRCTR_IDX_MODE: rbyte = s_q.mode;
      `TMRCTR_IDX_LO0: rbyte = s_q.lo[0];
      `TMRCTR_IDX_HI0: rbyte = s_q.hi[0];
      `TMRCTR_IDX_LO1: rbyte = s_q.lo[1];
      `TMRCTR_IDX_HI1: rbyte = s_q.hi[1];
      `TMRCTR_IDX_CLK: rbyte = {6'h00, s_q.divsel};
      default: rbyte = 8'h00;
    endcase

    // answer one cycle into the access phase
    s_d.rsp.pready = acc & ~s_q.rsp.pready;
    if (acc && !s_q.rsp.pready)
    begin
      s_d.rsp.prdata = (hit && !apb_req.pwrite) ? {24'h000000, rbyte} : 32'h00000000;
      s_d.rsp.pslverr = ~hit;
    end
    else
    begin
      s_d.rsp.prdata = 32'h00000000;
      s_d.rsp.pslverr = 1'b0;
    end

    // software write wins over a count in the same cycle
    if (done && apb_req.pwrite && hit)
    begin
      case (idx)
        `TMRCTR_IDX_CTRL: s_d.ctrl = apb_req.pwdata[7:0];
        `TMRCTR_IDX_MODE: s_d.mode = apb_req.pwdata[7:0];
        `TMRCTR_IDX_LO0: s_d.lo[0] = apb_req.pwdata[7:0];
        `TMRCTR_IDX_HI0: s_d.hi[0] = apb_req.pwdata[7:0];
        `TMRCTR_IDX_LO1: s_d.lo[1] = apb_req.pwdata[7:0];
        `TMRCTR_IDX_HI1: s_d.hi[1] = apb_req.pwdata[7:0];
        `TMRCTR_IDX_CLK: s_d.divsel = apb_req.pwdata[1:0];
        default: s_d.ctrl = s_d.ctrl;
      endcase
    end

    // vector acknowledge clears, a hardware set in the same cycle wins
    if (vector_ack.overflow_flag_one)
    begin
      s_d.ctrl[`TMRCTR_OVF1] = 1'b0;
    end
    if (vector_ack.overflow_flag_zero)
    begin
      s_d.ctrl[`TMRCTR_OVF0] = 1'b0;
    end
    if (vector_ack.ext_irq_flag_one)
    begin
      s_d.ctrl[`TMRCTR_EXF1] = 1'b0;
    end
    if (vector_ack.ext_irq_flag_zero)
    begin
      s_d.ctrl[`TMRCTR_EXF0] = 1'b0;
    end
    s_d.ctrl[`TMRCTR_OVF0] = s_d.ctrl[`TMRCTR_OVF0] | ov0;
    s_d.ctrl[`TMRCTR_OVF1] = s_d.ctrl[`TMRCTR_OVF1] | ov1;
    s_d.ctrl[`TMRCTR_EXF0] = s_d.ctrl[`TMRCTR_EXF0] | ext_set[0];
    s_d.ctrl[`TMRCTR_EXF1] = s_d.ctrl[`TMRCTR_EXF1] | ext_set[1];

    s_d.flags = {s_d.ctrl[`TMRCTR_OVF1], s_d.ctrl[`TMRCTR_OVF0],
                 s_d.ctrl[`TMRCTR_EXF1], s_d.ctrl[`TMRCTR_EXF0]};
  end

  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      s_q.ctrl <= `TMRCTR_RST_BYTE;
      s_q.mode <= `TMRCTR_RST_BYTE;
      s_q.lo <= {2{`TMRCTR_RST_BYTE}};
      s_q.hi <= {2{`TMRCTR_RST_BYTE}};
      s_q.divsel <= `TMRCTR_RST_SEL;
      s_q.pre <= 4'h0;
      // pins idle high, so no false edge right after reset
      s_q.pin_s1 <= 4'hF;
      s_q.pin_s2 <= 4'hF;
      s_q.irq_prev <= 2'h3;
      s_q.cnt_samp <= 2'h3;
      s_q.rsp <= '0;
      s_q.flags <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign apb_rsp = s_q.rsp;
  assign flags = s_q.flags;

endmodule

// ===== tmrctr_checker.sv
module tmrctr_checker
  import tmrctr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire tmrctr_pkg::tmrctr_apb_req_t apb_req,
  input wire tmrctr_pkg::tmrctr_apb_rsp_t apb_rsp,
  input wire tmrctr_pkg::tmrctr_pins_t pins,
  input wire tmrctr_pkg::tmrctr_flags_t vector_ack,
  input wire tmrctr_pkg::tmrctr_flags_t flags
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic acc;
  logic bad;
  assign acc = apb_req.psel && apb_req.penable;
  assign bad = apb_req.paddr[1:0] != 2'h0 || apb_req.paddr < 12'h220 || apb_req.paddr > 12'h238;
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready too long");
  a_ready_wait: assert property ($rose(apb_req.penable) && apb_req.psel |=> apb_rsp.pready)
    else $error("pready late");
  a_ready_access: assert property (apb_rsp.pready |-> acc)
    else $error("pready idle");
  a_err_decode: assert property (acc && apb_rsp.pready |-> apb_rsp.pslverr == bad)
    else $error("pslverr wrong");
  a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr alone");
  a_byte_data: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("prdata high bits");
  a_ext_zero: assert property ($fell(pins.ext_irq_pin_zero) |-> ##[2:4] flags.ext_irq_flag_zero)
    else $error("ext flag 0 not set");
  a_ext_one: assert property ($fell(pins.ext_irq_pin_one) |-> ##[2:4] flags.ext_irq_flag_one)
    else $error("ext flag 1 not set");
  c_ovf0: cover property (flags.overflow_flag_zero);
  c_ovf1: cover property (flags.overflow_flag_one);
  c_err: cover property (apb_rsp.pslverr);
endmodule

bind tmrctr_top tmrctr_checker u_chk (.sys_clk(sys_clk), .resetn(resetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .pins(pins), .vector_ack(vector_ack), .flags(flags));

// ===== tmrctr_pin_model.sv
module tmrctr_pin_model
  import tmrctr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [1:0] run,
  input wire logic [1:0] irq_lvl,
  output tmrctr_pkg::tmrctr_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt = 3'h0;
  logic [1:0] lvl = 2'h3;
  // each level stands 8 cycles, two sampling machine cycles
  always @(posedge sys_clk)
  begin
    cnt <= cnt + 3'h1;
    if (cnt == 3'h7)
      lvl <= lvl ^ run;
  end
  assign pins = {lvl, irq_lvl};
endmodule

// ===== tb_dual_timer_counter_modes.sv
module tb_dual_timer_counter_modes;
  import tmrctr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  tmrctr_apb_req_t req = '0;
  tmrctr_apb_rsp_t rsp;
  tmrctr_pins_t pins;
  tmrctr_flags_t ack = '0;
  tmrctr_flags_t flags;
  logic [1:0] run = 2'h0;
  logic [1:0] irq = 2'h3;
  logic [31:0] rd;
  logic err;
  logic [31:0] seed = 32'h1050;
  logic [7:0] v;
  int bad_count = 0;
  int comparisons = 0;
  int falls = 0;
  int n;

  tmrctr_top dut (.sys_clk(sys_clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
    .pins(pins), .vector_ack(ack), .flags(flags));
  tmrctr_pin_model far (.sys_clk(sys_clk), .run(run), .irq_lvl(irq), .pins(pins));

  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(negedge pins.count_pin_zero) falls++;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic wrap_up;
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h0, d}};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic pulse_ack(input int b);
    @(posedge sys_clk);
    ack[b] <= 1'b1;
    @(posedge sys_clk);
    ack <= '0;
    repeat (2) @(posedge sys_clk);
  endtask

  // count up to wrap from 16 ticks below it, then stop with the flag kept
  task automatic ovf(input int t, input logic [7:0] ck, md, lo, input int dv);
    apb(1, 12'h238, ck);
    apb(1, 12'h224, md);
    apb(1, t ? 12'h230 : 12'h228, lo);
    apb(1, t ? 12'h234 : 12'h22C, 8'hFF);
    apb(1, 12'h220, t ? 8'h40 : 8'h10);
    n = 0;
    while (flags[t+2] !== 1'b1 && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("wrap time", 1, n >= 15 * dv && n <= 17 * dv);
    apb(1, 12'h220, t ? 8'h80 : 8'h20);
    apb(0, 12'h220, 8'h00);
    chk("ovf flag", t ? 8'h80 : 8'h20, rd);
    apb(0, t ? 12'h234 : 12'h22C, 8'h00);
    chk("high wrap", 0, rd);
    apb(0, t ? 12'h230 : 12'h228, 8'h00);
    v = rd[7:0];
    if (t)
      chk("low5 wrap", 0, rd[4:0]);
    repeat (40) @(posedge sys_clk);
    apb(0, t ? 12'h230 : 12'h228, 8'h00);
    chk("low held", v, rd);
    pulse_ack(t + 2);
    chk("flag ack", 0, flags[t+2]);
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(0, 12'h220, 0);
    chk("ctrl reset", 0, rd);
    apb(0, 12'h224, 0);
    chk("mode reset", 0, rd);
    apb(0, 12'h23C, 0);
    chk("unmapped", 1, err);
    for (int i = 0; i < 5; i++)
    begin
      seed = xs(seed);
      apb(1, 12'h224 + 12'(4 * i), seed[7:0]);
      apb(0, 12'h224 + 12'(4 * i), 0);
      chk("reg rw", {24'h0, seed[7:0]}, rd);
    end
    ovf(0, 8'h01, 8'h01, 8'hF0, 4);
    ovf(1, 8'h00, 8'h00, 8'h10, 12);
    @(posedge sys_clk);
    irq <= 2'h1;
    apb(1, 12'h224, 8'h95);
    for (int i = 0; i < 4; i++)
      apb(1, 12'h228 + 12'(4 * i), 0);
    apb(1, 12'h220, 8'h50);
    falls = 0;
    run <= 2'h1;
    wait (falls == 5);
    @(posedge sys_clk);
    run <= 2'h0;
    repeat (40) @(posedge sys_clk);
    apb(0, 12'h228, 0);
    chk("event count", falls, rd);
    apb(0, 12'h230, 0);
    chk("gated count", 0, rd);
    chk("level flag", 1, flags.ext_irq_flag_one);
    apb(1, 12'h220, 8'h01);
    irq <= 2'h0;
    repeat (6) @(posedge sys_clk);
    chk("edge flag", 1, flags.ext_irq_flag_zero);
    pulse_ack(0);
    chk("edge ack", 0, flags.ext_irq_flag_zero);
    // reload mode on timer 0 while timer 1 sits in mode 3
    irq <= 2'h3;
    apb(1, 12'h238, 8'h03);
    apb(1, 12'h224, 8'h32);
    apb(1, 12'h228, 8'hFC);
    apb(1, 12'h22C, 8'hF8);
    apb(1, 12'h230, 8'h5A);
    apb(1, 12'h234, 8'hA5);
    apb(1, 12'h220, 8'h50);
    repeat (40) @(posedge sys_clk);
    apb(0, 12'h220, 0);
    chk("reload flags", 8'h20, rd & 8'hA0);
    apb(1, 12'h220, 0);
    apb(0, 12'h228, 0);
    chk("reload range", 8'hF8, rd & 8'hF8);
    apb(0, 12'h22C, 0);
    chk("reload kept", 8'hF8, rd);
    apb(0, 12'h230, 0);
    chk("mode3 low", 8'h5A, rd);
    apb(0, 12'h234, 0);
    chk("mode3 high", 8'hA5, rd);
    // split: timer 0 high byte runs on run1 into ovf1, its low byte holds, timer 1 free-runs
    apb(1, 12'h224, 8'h03);
    apb(1, 12'h228, 8'hF0);
    apb(1, 12'h22C, 8'hF8);
    apb(1, 12'h220, 8'h40);
    repeat (40) @(posedge sys_clk);
    apb(0, 12'h220, 0);
    chk("split flags", 8'h80, rd & 8'hA0);
    apb(1, 12'h220, 0);
    apb(0, 12'h228, 0);
    chk("split low", 8'hF0, rd);
    apb(0, 12'h22C, 0);
    chk("split high", 0, rd[7:3]);
    wrap_up;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    wrap_up;
  end
endmodule
